// ### verilog/dbgbu_top.sv
// debug breakpoint unit: registers, comparators and debug exceptions
//
// Function
// - four 32-bit linear breakpoint addresses compared continuously
// - compare linear addresses, never translated ones
// - all breakpoints disabled after reset
// - debug breakpoints use vector 1 only
// - length 00 compares all address bits
// - length 01 ignores address bit 0
// - length 11 ignores address bits 1, 0
// - usage field: execute, write, read/write
// - execution fault before, data trap after
// - overlapping data access traps on vector 1
// - breakpoint opcode traps on vector 3
// - only general interrupt checks privilege level
// - single-step flag set at end traps
// - single-step trap one instruction later
// - single-step return pointer is next instruction
// - six debug registers are present
// - local or global enable arms breakpoint
// - hit flag set when condition occurs
// - status flags set by hardware and by software writes
`timescale 1ns/10ps
`include "dbgbu_consts.svh"
module dbgbu_top
	import dbgbu_pkg::*;
#(
	parameter logic [7:0] GP_VECTOR = 8'h0d
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire dbgbu_fetch_s fetch,
	input wire dbgbu_data_s data,
	input wire dbgbu_retire_s retire,
	output dbgbu_exc_s exc
);
	dbgbu_state_s q;
	dbgbu_state_s d;

	logic [3:0] exec_hit;
	logic [3:0] data_hit;
	logic [3:0] enabled;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
	endfunction

	// register index of a byte address, 3'h7 when unmapped
	function automatic logic [2:0] decode(input logic [7:0] a);
		case (a)
			`DBGBU_OFF_BPA0: decode = 3'h0;
			`DBGBU_OFF_BPA1: decode = 3'h1;
			`DBGBU_OFF_BPA2: decode = 3'h2;
			`DBGBU_OFF_BPA3: decode = 3'h3;
			`DBGBU_OFF_STATUS: decode = 3'h4;
			`DBGBU_OFF_CONTROL: decode = 3'h5;
			default: decode = 3'h7;
		endcase
	endfunction

	// per-breakpoint field of the active control word
	function automatic dbgbu_code_t field(input logic [31:0] c,
		input int i, input int pos);
		field = c[pos + i*`DBGBU_CTL_STRIDE +: 2];
	endfunction

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			enabled[i] = q.ctrl_act[`DBGBU_CTL_LOCAL_POS + 2*i] |
				q.ctrl_act[`DBGBU_CTL_GLOBAL_POS + 2*i];
		end
	end

	// comparators see the linear address as given
	for (genvar g = 0; g < 4; g++) begin : g_bp
		dbgbu_match u_exec (
			.bp_addr(q.bp_act[g]),
			.bp_len(field(q.ctrl_act, g, `DBGBU_CTL_LEN_POS)),
			.bp_rw(field(q.ctrl_act, g, `DBGBU_CTL_RW_POS)),
			.acc_addr(fetch.addr),
			.acc_len(`DBGBU_LEN_1),
			.acc_exec(1'b1),
			.acc_write(1'b0),
			.hit(exec_hit[g])
		);
		dbgbu_match u_data (
			.bp_addr(q.bp_act[g]),
			.bp_len(field(q.ctrl_act, g, `DBGBU_CTL_LEN_POS)),
			.bp_rw(field(q.ctrl_act, g, `DBGBU_CTL_RW_POS)),
			.acc_addr(data.addr),
			.acc_len(data.len),
			.acc_exec(1'b0),
			.acc_write(data.write),
			.hit(data_hit[g])
		);
	end

	// handshake readies come straight from held state
	assign s_axi_awready = !q.aw_held && !q.bvalid;
	assign s_axi_wready = !q.w_held && !q.bvalid;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;
	assign exc = q.exc;

	// next state: bus slave, then flags, then exceptions
	always_comb begin
		logic aw_ok;
		logic w_ok;
		logic [7:0] waddr;
		logic [31:0] wd;
		logic [3:0] ws;
		logic [2:0] idx;
		logic [3:0] fetch_hit;
		logic [3:0] dnow;
		logic [31:0] sets;
		logic ss_trap;
		logic gp;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		waddr = 8'h00;
		wd = 32'h0000_0000;
		ws = 4'h0;
		idx = 3'h7;
		fetch_hit = 4'h0;
		dnow = 4'h0;
		sets = 32'h0000_0000;
		ss_trap = 1'b0;
		gp = 1'b0;
		d = q;
		d.exc.valid = 1'b0;

		// address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_held = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_held = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		aw_ok = d.aw_held;
		w_ok = d.w_held;
		waddr = d.aw_addr;
		wd = d.w_data;
		ws = d.w_strb;
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// six registers, unmapped gets an error
		if (aw_ok && w_ok && !q.bvalid) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `DBGBU_RESP_OKAY;
			idx = decode(waddr);
			case (idx)
				3'h0, 3'h1, 3'h2, 3'h3: begin
					d.bp_sw[idx[1:0]] =
						merge(q.bp_sw[idx[1:0]], wd, ws);
				end
				3'h4: begin
					d.status = merge(q.status, wd, ws);
				end
				3'h5: begin
					d.ctrl_sw = merge(q.ctrl_sw, wd, ws);
				end
				default: begin
					d.bresp = `DBGBU_RESP_SLVERR;
				end
			endcase
		end

		// read answer is registered, held until taken
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rresp = `DBGBU_RESP_OKAY;
			case (decode(s_axi_araddr))
				3'h0: d.rdata = q.bp_sw[0];
				3'h1: d.rdata = q.bp_sw[1];
				3'h2: d.rdata = q.bp_sw[2];
				3'h3: d.rdata = q.bp_sw[3];
				3'h4: d.rdata = q.status;
				3'h5: d.rdata = q.ctrl_sw;
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = `DBGBU_RESP_SLVERR;
				end
			endcase
		end

		// flags follow raw conditions, enabled or not
		if (fetch.valid) begin
			fetch_hit = exec_hit;
		end
		if (data.valid) begin
			dnow = data_hit;
		end
		sets[3:0] = fetch_hit | dnow;

		if (retire.valid) begin
			// software copies go live at a boundary
			d.bp_act = q.bp_sw;
			d.ctrl_act = q.ctrl_sw;
			// arm now, trap after the next one
			d.ss_armed = retire.flags[`DBGBU_FLAGS_SS_POS];
			// flag seen set at previous end
			ss_trap = q.ss_armed;
			// only the general form is privilege checked
			gp = (retire.kind == DBGBU_KIND_INTN) &&
				retire.prot_mode && (retire.cpl > retire.io_privilege_level);
			d.dpend = 4'h0;
			d.exc.valid = 1'b1;
			d.exc.fault = 1'b0;
			// traps return to the next instruction
			d.exc.return_ptr = retire.next_ptr;
			if (gp) begin
				d.exc.fault = 1'b1;
				d.exc.vector = GP_VECTOR;
				d.exc.return_ptr = retire.this_ptr;
			end else if (|((q.dpend | dnow) & enabled) ||
				ss_trap) begin
				d.exc.vector = `DBGBU_VEC_DEBUG;
				sets[`DBGBU_STAT_SS_POS] = ss_trap;
			end else if (retire.kind == DBGBU_KIND_INT3) begin
				d.exc.vector = `DBGBU_VEC_BKPT;
			end else if (retire.kind == DBGBU_KIND_INTN) begin
				d.exc.vector = retire.intn_vec;
			end else begin
				d.exc.valid = 1'b0;
			end
		end else begin
			// data hits wait for the end of the instruction
			d.dpend = q.dpend | (dnow & enabled);
			if (fetch.valid && |(exec_hit & enabled)) begin
				d.exc.valid = 1'b1;
				d.exc.fault = 1'b1;
				d.exc.vector = `DBGBU_VEC_DEBUG;
				d.exc.return_ptr = fetch.addr;
			end
		end

		// set after the software write: set wins
		d.status = d.status | sets;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.bp_sw <= {4{`DBGBU_BPA_RESET}};
			q.bp_act <= {4{`DBGBU_BPA_RESET}};
			q.ctrl_sw <= `DBGBU_CONTROL_RESET;
			q.ctrl_act <= `DBGBU_CONTROL_RESET;
			q.status <= `DBGBU_STATUS_RESET;
		end else begin
			q <= d;
		end
	end
endmodule

// ### verilog/dbgbu_consts.svh
// offsets, field positions, reset values and codes of the debug unit
`ifndef DBGBU_CONSTS_SVH
`define DBGBU_CONSTS_SVH
`define DBGBU_OFF_BPA0 8'h00
`define DBGBU_OFF_BPA1 8'h04
`define DBGBU_OFF_BPA2 8'h08
`define DBGBU_OFF_BPA3 8'h0c
`define DBGBU_OFF_STATUS 8'h10
`define DBGBU_OFF_CONTROL 8'h14
`define DBGBU_BPA_RESET 32'h0000_0000
`define DBGBU_STATUS_RESET 32'h0000_0000
`define DBGBU_CONTROL_RESET 32'h0000_0000
`define DBGBU_CTL_LOCAL_POS 0
`define DBGBU_CTL_GLOBAL_POS 1
`define DBGBU_CTL_RW_POS 16
`define DBGBU_CTL_LEN_POS 18
`define DBGBU_CTL_STRIDE 4
`define DBGBU_STAT_SS_POS 14
`define DBGBU_FLAGS_SS_POS 8
`define DBGBU_LEN_1 2'b00
`define DBGBU_LEN_2 2'b01
`define DBGBU_LEN_4 2'b11
`define DBGBU_RW_EXEC 2'b00
`define DBGBU_RW_WRITE 2'b01
`define DBGBU_RW_RDWR 2'b11
`define DBGBU_VEC_DEBUG 8'h01
`define DBGBU_VEC_BKPT 8'h03
`define DBGBU_RESP_OKAY 2'b00
`define DBGBU_RESP_SLVERR 2'b10
`endif

// ### verilog/dbgbu_pkg.sv
// types shared by the debug breakpoint unit
package dbgbu_pkg;
	typedef logic [1:0] dbgbu_code_t;

	// kind of a retiring instruction, one-hot
	typedef enum logic [2:0] {
		DBGBU_KIND_PLAIN = 3'b001,
		DBGBU_KIND_INT3 = 3'b010,
		DBGBU_KIND_INTN = 3'b100
	} dbgbu_kind_e;

	// instruction about to execute
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
	} dbgbu_fetch_s;

	// completed data transfer
	typedef struct packed {
		logic valid;
		logic write;
		dbgbu_code_t len;
		logic [31:0] addr;
	} dbgbu_data_s;

	// instruction boundary report
	typedef struct packed {
		logic valid;
		dbgbu_kind_e kind;
		logic [7:0] intn_vec;
		logic [31:0] flags;
		logic prot_mode;
		logic [1:0] cpl;
		logic [1:0] io_privilege_level;
		logic [31:0] this_ptr;
		logic [31:0] next_ptr;
	} dbgbu_retire_s;

	// exception request to the execution unit
	typedef struct packed {
		logic valid;
		logic fault;
		logic [7:0] vector;
		logic [31:0] return_ptr;
	} dbgbu_exc_s;

	// whole state of the top module
	typedef struct packed {
		logic [3:0][31:0] bp_sw;
		logic [31:0] ctrl_sw;
		logic [3:0][31:0] bp_act;
		logic [31:0] ctrl_act;
		logic [31:0] status;
		logic [3:0] dpend;
		logic ss_armed;
		dbgbu_exc_s exc;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} dbgbu_state_s;
endpackage

// ### verilog/dbgbu_match.sv
// one breakpoint comparator for an execution or a data access
`timescale 1ns/10ps
`include "dbgbu_consts.svh"
module dbgbu_match
	import dbgbu_pkg::*;
(
	input wire logic [31:0] bp_addr,
	input wire dbgbu_code_t bp_len,
	input wire dbgbu_code_t bp_rw,
	input wire logic [31:0] acc_addr,
	input wire dbgbu_code_t acc_len,
	input wire logic acc_exec,
	input wire logic acc_write,
	output logic hit
);
	// size minus one of a length code; the undefined code acts as one byte
	function automatic logic [31:0] span(input dbgbu_code_t c);
		case (c)
			`DBGBU_LEN_2: span = 32'h0000_0001;
			`DBGBU_LEN_4: span = 32'h0000_0003;
			default: span = 32'h0000_0000;
		endcase
	endfunction

	logic [32:0] bbase;
	logic [32:0] bend;
	logic [32:0] aend;
	logic [31:0] mask;
	logic overlap;

	// 33-bit ends so an access near the top does not wrap
	always_comb begin
		mask = span(bp_len);
		bbase = {1'b0, bp_addr & ~mask};
		bend = bbase + {1'b0, mask};
		aend = {1'b0, acc_addr} + {1'b0, span(acc_len)};
		overlap = ({1'b0, acc_addr} <= bend) && (bbase <= aend);
		hit = 1'b0;
		if (acc_exec) begin
			hit = (bp_rw == `DBGBU_RW_EXEC) &&
				((acc_addr & ~mask) == bbase[31:0]);
		end else if (bp_rw == `DBGBU_RW_WRITE) begin
			hit = acc_write && overlap;
		end else if (bp_rw == `DBGBU_RW_RDWR) begin
			hit = overlap;
		end
	end
endmodule

// ### test/dbgbu_top_chk.sv
// port assertions for the debug breakpoint unit
`timescale 1ns/10ps
module dbgbu_top_chk
	import dbgbu_pkg::*;
#(
	parameter logic [7:0] GP_VECTOR = 8'h0d
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire dbgbu_fetch_s fetch,
	input wire dbgbu_retire_s retire,
	input wire dbgbu_exc_s exc
);
	// one clock domain, everything quiet while reset is low
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_fault_exec: assert property (
		exc.valid && exc.fault && !$past(retire.valid) |-> $past(fetch.valid)
		&& exc.vector == 8'h01 && exc.return_ptr == $past(fetch.addr))
		else $error("bad execution fault");
	chk_trap_ptr: assert property (
		exc.valid && !exc.fault |->
		$past(retire.valid) && exc.return_ptr == $past(retire.next_ptr))
		else $error("bad trap return pointer");
	chk_int3_vec: assert property (
		retire.valid && retire.kind == DBGBU_KIND_INT3 |=> exc.valid
		&& !exc.fault && exc.vector inside {8'h01, 8'h03})
		else $error("bad breakpoint opcode trap");
	chk_intn_gp: assert property (
		retire.valid && retire.kind == DBGBU_KIND_INTN && retire.prot_mode
		&& retire.cpl > retire.io_privilege_level |=> exc.valid && exc.fault
		&& exc.vector == GP_VECTOR) else $error("missing privilege fault");
	chk_exc_cause: assert property (
		exc.valid |-> $past(fetch.valid) || $past(retire.valid))
		else $error("exception without cause");
	chk_aw_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response open");
	chk_ar_block: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
	chk_ar_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
endmodule

bind dbgbu_top dbgbu_top_chk #(.GP_VECTOR(GP_VECTOR)) i_dbgbu_top_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .fetch(fetch), .retire(retire), .exc(exc));

// ### test/dbgbu_cpu.sv
// processor-side model driving fetch, data and retire reports
`timescale 1ns/10ps
module dbgbu_cpu
	import dbgbu_pkg::*;
(
	input wire logic aclk,
	output dbgbu_fetch_s fetch,
	output dbgbu_data_s data,
	output dbgbu_retire_s retire
);
	// idle fetch starts with all-ones junk, data and retire start at zero; none look valid
	initial begin
		fetch = '{1'b0, 32'hffff_ffff};
		data = '0;
		retire = '0;
	end

	task fe(input logic [31:0] a);
		@(posedge aclk);
		fetch <= '{1'b1, a};
		@(posedge aclk);
		fetch <= '{1'b0, ~a};
	endtask

	// length code 10 is never sent
	task da(input logic w, input dbgbu_code_t l, input logic [31:0] a);
		@(posedge aclk);
		data <= '{1'b1, w, l, a};
		@(posedge aclk);
		data <= '{1'b0, ~w, l, ~a};
	endtask

	task re(input dbgbu_kind_e k, input logic [7:0] v,
		input logic [31:0] fl, input logic [1:0] cpl, input logic [31:0] p);
		@(posedge aclk);
		retire <= '{1'b1, k, v, fl, 1'b1, cpl, 2'h0, p, p + 32'h4};
		// idle fields other than kind inverted so nothing stale looks meaningful
		@(posedge aclk);
		retire <= '{1'b0, k, ~v, ~fl, 1'b0, ~cpl, 2'h3, ~p, ~p};
	endtask
endmodule

// ### test/dbgbu_top_test.sv
// self-checking bench for the debug breakpoint unit
`timescale 1ns/10ps
module dbgbu_top_test
	import dbgbu_pkg::*;
;
	localparam logic [7:0] GPV = 8'h0d;
	// rw,len / wr,alen / addr low byte / hit; no code 10 anywhere
	localparam logic [19:0] LT [9] = '{20'hc0040, 20'hc0051, 20'hd0041,
		20'hd0060, 20'hf0071, 20'hf0080, 20'hf1031, 20'h73040, 20'h7b041};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	// strobes and protection bits are driven so byte lanes get exercised
	logic [3:0] ws = 4'hf;
	logic [2:0] prot = 3'h0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic awr, wrd, bv, arr, rv;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, got;
	dbgbu_fetch_s fetch;
	dbgbu_data_s data;
	dbgbu_retire_s retire;
	dbgbu_exc_s exc;
	int failures = 0;
	int total_checks = 0;

	dbgbu_top #(.GP_VECTOR(GPV)) i_dbgbu_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awprot(prot), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arprot(prot), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .fetch(fetch), .data(data), .retire(retire),
		.exc(exc));
	dbgbu_cpu i_dbgbu_cpu (.aclk(aclk), .fetch(fetch), .data(data),
		.retire(retire));

	// 50 MHz clock
	initial begin
		forever #10 aclk = ~aclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// handshakes are judged at the rising edge, released right after it
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (!ta && awr) begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (!tw && wrd) begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
		end while (!bv);
		check(32'(bresp), 32'(er));
		br <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
		end while (!arr);
		arv <= 1'b0;
		do begin
			@(posedge aclk);
		end while (!rv);
		d = rdata;
		check(32'(rresp), 32'(er));
		rr <= 1'b0;
	endtask

	task nx;
		#1;
		check(32'(exc.valid), 32'h0);
	endtask

	task xc(input logic f, input logic [7:0] v, input logic [31:0] p);
		#1;
		check(32'(exc.valid), 32'h1);
		check(32'(exc.fault), 32'(f));
		check(32'(exc.vector), 32'(v));
		check(exc.return_ptr, p);
	endtask

	task rp(input logic [31:0] fl, input logic [31:0] p);
		i_dbgbu_cpu.re(DBGBU_KIND_PLAIN, 8'h00, fl, 2'h0, p);
	endtask

	task t_reset;
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), got, 2'b00);
			check(got, 32'h0);
		end
		rd(8'h18, got, 2'b10);
		check(got, 32'h0);
		wr(8'h18, 32'hffff_ffff, 2'b10);
		// one byte lane only; protection bits have no effect
		ws <= 4'h2;
		prot <= 3'h7;
		wr(8'h08, 32'ha5a5_a5a5, 2'b00);
		ws <= 4'hf;
		rd(8'h08, got, 2'b00);
		check(got, 32'h0000_a500);
		i_dbgbu_cpu.fe(32'h40);
		nx;
	endtask

	// reset in mid-run must drop an armed breakpoint and single step
	task t_rearm;
		wr(8'h00, 32'h40, 2'b00);
		wr(8'h14, 32'h3, 2'b00);
		rp(32'h100, 32'h900);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		i_dbgbu_cpu.fe(32'h40);
		nx;
		rp(32'h0, 32'h940);
		nx;
		rd(8'h14, got, 2'b00);
		check(got, 32'h0);
	endtask

	task t_exec;
		wr(8'h00, 32'h2000, 2'b00);
		wr(8'h14, 32'h1, 2'b00);
		i_dbgbu_cpu.fe(32'h2000);
		nx;
		rp(32'h0, 32'h10);
		nx;
		i_dbgbu_cpu.fe(32'h2001);
		nx;
		i_dbgbu_cpu.fe(32'h2000);
		xc(1'b1, 8'h01, 32'h2000);
		rd(8'h10, got, 2'b00);
		check(got, 32'h1);
		rp(32'h0, 32'h20);
		rd(8'h10, got, 2'b00);
		check(got, 32'h1);
		wr(8'h10, 32'h0, 2'b00);
		rd(8'h10, got, 2'b00);
		check(got, 32'h0);
	endtask

	task t_len;
		logic [19:0] c;
		wr(8'h04, 32'h105, 2'b00);
		for (int i = 0; i < 9; i++) begin
			c = LT[i];
			wr(8'h14, {8'h00, c[17:16], c[19:18], 20'h00008}, 2'b00);
			rp(32'h0, 32'h200);
			i_dbgbu_cpu.da(c[15], c[13:12], 32'h100 | 32'(c[11:4]));
			rp(32'h0, 32'h300);
			#1;
			check(32'(exc.valid), 32'(c[0]));
			if (c[0]) check(32'(exc.vector), 32'h1);
		end
	endtask

	task t_step;
		rp(32'h100, 32'h400);
		nx;
		rp(32'h0, 32'h500);
		xc(1'b0, 8'h01, 32'h504);
		rd(8'h10, got, 2'b00);
		check(32'(got[14]), 32'h1);
		rp(32'h0, 32'h540);
		nx;
	endtask

	task t_int;
		i_dbgbu_cpu.re(DBGBU_KIND_INT3, 8'h03, 32'h0, 2'h3, 32'h600);
		xc(1'b0, 8'h03, 32'h604);
		i_dbgbu_cpu.re(DBGBU_KIND_INTN, 8'h21, 32'h0, 2'h3, 32'h700);
		xc(1'b1, GPV, 32'h700);
		i_dbgbu_cpu.re(DBGBU_KIND_INTN, 8'h21, 32'h0, 2'h0, 32'h800);
		xc(1'b0, 8'h21, 32'h804);
	endtask

	// reset for 12 cycles, then every scenario in turn
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_exec;
		t_len;
		t_step;
		t_int;
		t_rearm;
		end_of_test;
	end

	// watchdog well above the expected few hundred cycles
	initial begin
		#200000;
		failures++;
		end_of_test;
	end
endmodule
